/* inc/air_pkg.sv */
package air_pkg;
  // register map of the routing block, byte-wide internal register port
  localparam logic [7:0] REG_ENABLE_MASK = 8'h2D;
  localparam logic [7:0] REG_PIN_ROUTING = 8'h2E;
  localparam logic [7:0] REG_SOURCE = 8'h0C;
  localparam logic [7:0] REG_CONTROL3 = 8'h2C;
  // source bit positions, shared by enable, routing and source registers
  localparam int BIT_SLEEP_WAKE = 7;
  localparam int BIT_TRANSIENT = 5;
  localparam int BIT_ORIENTATION = 4;
  localparam int BIT_PULSE = 3;
  localparam int BIT_FALL_MOTION = 2;
  localparam int BIT_SAMPLE_READY = 0;
  localparam logic [7:0] SOURCE_BITS_MASK = 8'hBD;
  // polarity and drive-type bits of the control register
  localparam int BIT_IRQ_POLARITY = 1;
  localparam int BIT_IRQ_DRIVE_TYPE = 0;
  localparam logic [7:0] CONTROL3_IRQ_MASK = 8'h03;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] ROUTING_RESET = 8'h00;
  localparam logic [7:0] CONTROL3_RESET = 8'h00;
  localparam int PIN_SYNC_STAGES = 3;

  // register access request from the device's serial front end
  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } air_reg_req_type;

  // one open-drain-capable pin: level and active-low enable
  typedef struct packed {
    logic level;
    logic enable_b;
  } air_pin_type;

  typedef struct packed {
    logic [7:0] enableMask;
    logic [7:0] pinRouting;
    logic irqPolarity;
    logic irqDriveType;
    logic [7:0] rdata;
    logic rvalid;
    logic [7:0] pendingSync1;
    logic [7:0] pendingSync2;
    logic [7:0] pendingSync3;
    logic [7:0] pendingStable;
    air_pin_type pinA;
    air_pin_type pinB;
  } air_state_type;
endpackage

/* rtl/air_interrupt_router.sv */
`timescale 1ns/1ps
// Operation
// - enable bit 7 lets the sleep/wake event reach the pin routing.
// - enable bit 5 lets transient events reach the pin routing.
// - enable bit 4 lets orientation events reach the pin routing.
// - enable bit 3 lets pulse events reach the pin routing.
// - enable bit 2 lets freefall/motion events reach the pin routing.
// - enable bit 0 lets sample-ready events reach the pin routing.
// - all enable bits reset to 0 so no source drives a pin after reset.
// - flags of a disabled source never propagate to either pin.
// - routing bit 1 steers a source to pin A, 0 steers it to pin B.
// - all routing bits reset to 0, so sources default to pin B.
// - any enabled source routed to a pin can assert that pin.
// - an asserted pin drives low with polarity 0; with polarity 1 it drives high in push-pull and is released in open-drain.
// - drive type 0 is push-pull, 1 is open-drain.
module air_interrupt_router
  import air_pkg::*;
#(
  parameter int SOURCE_COUNT = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire air_reg_req_type regReq,
  input wire logic [7:0] eventPending,
  output logic [7:0] regRdata,
  output logic regRvalid,
  output logic irqPinAOut,
  output logic irqPinAEnable_b,
  output logic irqPinBOut,
  output logic irqPinBEnable_b
);

  // the register field layout is byte-wide; other widths cannot be served
  if (SOURCE_COUNT != 8) begin : g_bad_width
    $error("SOURCE_COUNT must be 8");
  end

  air_state_type state;
  air_state_type next_state;
  logic [7:0] gated;
  logic [7:0] flagsA;
  logic [7:0] flagsB;
  logic activeA;
  logic activeB;

  // turns a logical pin state into level and enable per polarity and drive
  function automatic air_pin_type drive_pin(input logic active,
                                            input logic polarity,
                                            input logic openDrain);
    air_pin_type p;
    p.level = active ? polarity : ~polarity;
    // open-drain only pulls low, so the line is released whenever the level would be high
    p.enable_b = openDrain ? (p.level == 1'b1) : 1'b0;
    if (openDrain) begin
      p.level = 1'b0;
    end
    return p;
  endfunction

  // per-source gating and steering, one slice per bit position
  for (genvar i = 0; i < SOURCE_COUNT; i++) begin : g_route
    assign gated[i] = state.enableMask[i] & state.pendingStable[i];
    assign flagsA[i] = gated[i] & state.pinRouting[i];
    assign flagsB[i] = gated[i] & ~state.pinRouting[i];
  end
  assign activeA = |flagsA;
  assign activeB = |flagsB;

  // register writes, reads and pin update in one next-state pass
  always_comb begin
    next_state = state;
    // pending flags arrive from the detection blocks on the sample clock
    next_state.pendingSync1 = eventPending;
    next_state.pendingSync2 = state.pendingSync1;
    next_state.pendingSync3 = state.pendingSync2;
    for (int b = 0; b < 8; b++) begin
      if (state.pendingSync2[b] == state.pendingSync3[b]) begin
        next_state.pendingStable[b] = state.pendingSync3[b];
      end
    end
    if (regReq.write) begin
      case (regReq.addr)
        REG_ENABLE_MASK: begin
          next_state.enableMask = regReq.wdata & SOURCE_BITS_MASK;
        end
        REG_PIN_ROUTING: begin
          next_state.pinRouting = regReq.wdata & SOURCE_BITS_MASK;
        end
        REG_CONTROL3: begin
          next_state.irqPolarity = regReq.wdata[BIT_IRQ_POLARITY];
          next_state.irqDriveType = regReq.wdata[BIT_IRQ_DRIVE_TYPE];
        end
        default: begin
        end
      endcase
    end
    next_state.rvalid = regReq.read;
    case (regReq.addr)
      REG_ENABLE_MASK: next_state.rdata = state.enableMask;
      REG_PIN_ROUTING: next_state.rdata = state.pinRouting;
      // source register shows enabled pending causes for the host
      REG_SOURCE: next_state.rdata = gated & SOURCE_BITS_MASK;
      REG_CONTROL3: next_state.rdata = {6'h00, state.irqPolarity,
                                        state.irqDriveType};
      default: next_state.rdata = 8'h00;
    endcase
    next_state.pinA = drive_pin(activeA, state.irqPolarity,
                                state.irqDriveType);
    next_state.pinB = drive_pin(activeB, state.irqPolarity,
                                state.irqDriveType);
    if (!rst_b) begin
      next_state = '0;
      next_state.enableMask = ENABLE_RESET;
      next_state.pinRouting = ROUTING_RESET;
      next_state.irqPolarity = CONTROL3_RESET[BIT_IRQ_POLARITY];
      next_state.irqDriveType = CONTROL3_RESET[BIT_IRQ_DRIVE_TYPE];
      // idle push-pull active-low pins sit high
      next_state.pinA.level = 1'b1;
      next_state.pinB.level = 1'b1;
    end
  end

  // all state registered on every edge, reset handled synchronously above
  always_ff @(posedge clk) begin
    state <= next_state;
  end

  assign regRdata = state.rdata;
  assign regRvalid = state.rvalid;
  assign irqPinAOut = state.pinA.level;
  assign irqPinAEnable_b = state.pinA.enable_b;
  assign irqPinBOut = state.pinB.level;
  assign irqPinBEnable_b = state.pinB.enable_b;

  // assertions
  property p_disabled_quiet;
    @(posedge clk) disable iff (!rst_b)
      (state.enableMask == 8'h00 && $past(state.enableMask) == 8'h00
       && !state.irqDriveType && !state.irqPolarity)
      |=> (irqPinAOut && irqPinBOut);
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("disabled sources drove an interrupt pin");

  property p_reset_enable;
    @(posedge clk) (!rst_b) |=> (state.enableMask == 8'h00);
  endproperty
  a_reset_enable: assert property (p_reset_enable)
    else $error("enable mask not cleared by reset");

  property p_reset_routing;
    @(posedge clk) (!rst_b) |=> (state.pinRouting == 8'h00);
  endproperty
  a_reset_routing: assert property (p_reset_routing)
    else $error("routing not cleared by reset");

  property p_route_a;
    @(posedge clk) disable iff (!rst_b)
      (activeA && !state.irqDriveType) |=>
        (irqPinAOut == $past(state.irqPolarity));
  endproperty
  a_route_a: assert property (p_route_a)
    else $error("pin A not asserted for routed source");

  property p_route_b;
    @(posedge clk) disable iff (!rst_b)
      (gated[BIT_SLEEP_WAKE] && !state.pinRouting[BIT_SLEEP_WAKE]
       && !state.irqDriveType) |=>
        (irqPinBOut == $past(state.irqPolarity));
  endproperty
  a_route_b: assert property (p_route_b)
    else $error("sleep/wake source did not assert pin B");

  property p_or_merge;
    @(posedge clk) disable iff (!rst_b)
      (!activeB && !state.irqDriveType) |=>
        (irqPinBOut == !$past(state.irqPolarity));
  endproperty
  a_or_merge: assert property (p_or_merge)
    else $error("pin B asserted with no routed pending source");

  property p_open_drain;
    @(posedge clk) disable iff (!rst_b)
      state.irqDriveType |=> (irqPinAOut == 1'b0 && irqPinBOut == 1'b0);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open-drain pin drove high");

  property p_push_pull;
    @(posedge clk) disable iff (!rst_b)
      (!state.irqDriveType ##1 !state.irqDriveType) |->
        (!irqPinAEnable_b && !irqPinBEnable_b);
  endproperty
  a_push_pull: assert property (p_push_pull)
    else $error("push-pull pin released");

  property p_enable_write;
    @(posedge clk) disable iff (!rst_b)
      (regReq.write && regReq.addr == REG_ENABLE_MASK) |=>
        (state.enableMask == ($past(regReq.wdata) & SOURCE_BITS_MASK));
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("enable mask write lost");

  // pins leave reset idle and driven, whatever was configured before
  property p_reset_pins;
    @(posedge clk) (!rst_b) |=>
      (irqPinAOut && irqPinBOut && !irqPinAEnable_b && !irqPinBEnable_b);
  endproperty
  a_reset_pins: assert property (p_reset_pins)
    else $error("interrupt pin not idle after reset");

  // a routing write must land with reserved bits cleared
  property p_routing_write;
    @(posedge clk) disable iff (!rst_b)
      (regReq.write && regReq.addr == REG_PIN_ROUTING) |=>
        (state.pinRouting == ($past(regReq.wdata) & SOURCE_BITS_MASK));
  endproperty
  a_routing_write: assert property (p_routing_write)
    else $error("routing write lost");

  // a disabled source must never show up as a cause for the host
  property p_source_masked;
    @(posedge clk) disable iff (!rst_b)
      (regReq.read && regReq.addr == REG_SOURCE) |=>
        ((regRdata & ~$past(state.enableMask)) == 8'h00);
  endproperty
  a_source_masked: assert property (p_source_masked)
    else $error("source register shows a disabled cause");
endmodule

/* dv/air_host_model.sv */
`timescale 1ns/1ps
// host side of the two irq lines, each with a board pull-up
module air_host_model (
  input wire logic levelA,
  input wire logic enableA_b,
  input wire logic levelB,
  input wire logic enableB_b,
  output logic wireA,
  output logic wireB
);
  // released line floats up, so a released open-drain pin reads high
  assign wireA = enableA_b ? 1'b1 : levelA;
  assign wireB = enableB_b ? 1'b1 : levelB;
endmodule

/* dv/tb_air_interrupt_router.sv */
`timescale 1ns/1ps
module tb_air_interrupt_router import air_pkg::*;;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  air_reg_req_type regReq = '0;
  logic [7:0] eventPending = 8'h00;
  logic [7:0] regRdata;
  logic regRvalid, outA, enA_b, outB, enB_b, wireA, wireB;
  logic pol = 1'b0;
  int miscompares = 0;
  int tests_run = 0;
  int srcBit[6] = '{7, 5, 4, 3, 2, 0};

  // 4 ns period
  always #2 clk = ~clk;

  air_interrupt_router u_air_interrupt_router (.clk(clk), .rst_b(rst_b),
    .regReq(regReq), .eventPending(eventPending), .regRdata(regRdata),
    .regRvalid(regRvalid), .irqPinAOut(outA), .irqPinAEnable_b(enA_b),
    .irqPinBOut(outB), .irqPinBEnable_b(enB_b));
  air_host_model u_air_host_model (.levelA(outA), .enableA_b(enA_b),
    .levelB(outB), .enableB_b(enB_b), .wireA(wireA), .wireB(wireB));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle strobes, released at the edge that takes them
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regReq <= '{1'b1, 1'b0, a, d};
    @(posedge clk);
    regReq <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    regReq <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk);
    regReq <= '0;
    #1;
    chk({7'h00, regRvalid}, 8'h01);
    chk(regRdata, exp);
  endtask
  // wait out the input synchroniser, then look at the wires
  task automatic pins(input logic a, input logic b);
    repeat (8) @(posedge clk);
    #1;
    chk({6'h00, wireA, wireB}, {6'h00, a ~^ pol, b ~^ pol});
  endtask
  // pending flags change on a rising edge, like every other input
  task automatic ev(input logic [7:0] v);
    @(posedge clk);
    eventPending <= v;
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // watchdog well beyond the expected run length
  initial begin
    #100000;
    miscompares++;
    summarize;
  end

  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    eventPending <= SOURCE_BITS_MASK;
    rd(REG_ENABLE_MASK, ENABLE_RESET);
    rd(REG_PIN_ROUTING, ROUTING_RESET);
    rd(REG_CONTROL3, CONTROL3_RESET);
    pins(1'b0, 1'b0);
    $display("test reset done");
    foreach (srcBit[i]) begin
      wr(REG_ENABLE_MASK, 8'h01 << srcBit[i]);
      wr(REG_PIN_ROUTING, 8'h01 << srcBit[i]);
      pins(1'b1, 1'b0);
      rd(REG_SOURCE, 8'h01 << srcBit[i]);
      wr(REG_PIN_ROUTING, 8'h00);
      pins(1'b0, 1'b1);
      wr(REG_ENABLE_MASK, SOURCE_BITS_MASK & ~(8'h01 << srcBit[i]));
      ev(8'h01 << srcBit[i]);
      pins(1'b0, 1'b0);
      ev(SOURCE_BITS_MASK);
    end
    $display("test per-source done");
    wr(REG_ENABLE_MASK, SOURCE_BITS_MASK);
    wr(REG_PIN_ROUTING, 8'h0C);
    ev(8'h04);
    pins(1'b1, 1'b0);
    ev(8'h0C);
    pins(1'b1, 1'b0);
    ev(8'h8D);
    pins(1'b1, 1'b1);
    ev(8'h81);
    pins(1'b0, 1'b1);
    ev(8'h00);
    pins(1'b0, 1'b0);
    $display("test merge done");
    // polarity active high, then open-drain with polarity low
    wr(REG_CONTROL3, 8'h02);
    pol = 1'b1;
    ev(8'h08);
    pins(1'b1, 1'b0);
    chk({6'h00, enA_b, enB_b}, 8'h00);
    wr(REG_CONTROL3, 8'h01);
    pol = 1'b0;
    ev(8'h00);
    pins(1'b0, 1'b0);
    chk({6'h00, enA_b, enB_b}, 8'h03);
    ev(8'h04);
    pins(1'b1, 1'b0);
    chk({6'h00, enA_b, enB_b}, 8'h01);
    $display("test pin drive done");
    wr(REG_ENABLE_MASK, 8'hFF);
    rd(REG_ENABLE_MASK, SOURCE_BITS_MASK);
    wr(8'h40, 8'hFF);
    rd(8'h40, 8'h00);
    wr(REG_CONTROL3, 8'hFF);
    rd(REG_CONTROL3, CONTROL3_IRQ_MASK);
    $display("test refusals done");
    // second reset with every register loaded and a source pending
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rd(REG_ENABLE_MASK, ENABLE_RESET);
    rd(REG_PIN_ROUTING, ROUTING_RESET);
    rd(REG_CONTROL3, CONTROL3_RESET);
    pins(1'b0, 1'b0);
    chk({6'h00, enA_b, enB_b}, 8'h00);
    $display("test second reset done");
    summarize;
  end
endmodule
